// file: pkg/tp_pkg.sv
// Shared constants and types for the touch controller host port
package tp_pkg;
  // Clock and map geometry
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          MEM_AW       = 4;
  localparam int          MEM_DW       = 8;
  localparam int          ACC_W        = 24;
  localparam logic [23:0] ACC_WRAP     = 24'h989680;
  // Target address and default frame rates in frames per second
  localparam logic [6:0]  DEF_DEV_ADDR = 7'h70;
  localparam logic [7:0]  DEF_ACT_FPS  = 8'h64;
  localparam logic [7:0]  DEF_MON_FPS  = 8'h19;
  // Byte offsets in the host-visible map, and the bit count of one byte
  localparam logic [3:0]  MODE_ADDR    = 4'h0;
  localparam logic [3:0]  ACT_FPS_ADDR = 4'h1;
  localparam logic [3:0]  MON_FPS_ADDR = 4'h2;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  // Timing
  localparam int          WDOG_MS      = 500;
  localparam int          WDOG_CYC     = (CLK_HZ / 1000) * WDOG_MS;
  localparam int          INIT_US      = 1000;
  localparam int          INIT_CYC     = (CLK_HZ / 1_000_000) * INIT_US;

  typedef enum logic [1:0] {
    MODE_ACTIVE  = 2'b00,
    MODE_MONITOR = 2'b01,
    MODE_SLEEP   = 2'b10
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_DATA  = 3'b011,
    ST_WR_ACK   = 3'b100,
    ST_RD_DATA  = 3'b101,
    ST_RD_ACK   = 3'b110
  } i2c_st_e;
endpackage

// file: verilog/tp_mem.sv
// Small two-port byte store for scan parameters and touch results
`timescale 1ns/1ps
`default_nettype none
module tp_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // Host side port, write wins over port b on the same address
  input  wire logic          a_wr_en_in,
  input  wire logic [AW-1:0] a_addr_in,
  input  wire logic [DW-1:0] a_wdata_in,
  output logic      [DW-1:0] a_rdata_out,
  // Core side port
  input  wire logic          b_wr_en_in,
  input  wire logic [AW-1:0] b_addr_in,
  input  wire logic [DW-1:0] b_wdata_in,
  output logic      [DW-1:0] b_rdata_out
);
  if (AW < 1 || AW > 8 || DW < 1) begin : g_bad_geom
    $error("tp_mem geometry out of range");
  end

  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_r[i] <= '0;
      end
      a_rdata_out <= '0;
      b_rdata_out <= '0;
    end else begin
      if (b_wr_en_in && !(a_wr_en_in && a_addr_in == b_addr_in)) begin
        mem_r[b_addr_in] <= b_wdata_in;
      end
      if (a_wr_en_in) begin
        mem_r[a_addr_in] <= a_wdata_in;
      end
      a_rdata_out <= mem_r[a_addr_in];
      b_rdata_out <= mem_r[b_addr_in];
    end
  end
endmodule
`default_nettype wire

// file: verilog/touch_host_port.sv
// Host port of the touch controller: I2C target, interrupt, modes, watchdog
`timescale 1ns/1ps
`default_nettype none
module touch_host_port #(
  parameter int WDOG_CYC_P = tp_pkg::WDOG_CYC,
  parameter int INIT_CYC_P = tp_pkg::INIT_CYC
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Pins: host reset, I2C, interrupt
  input  wire logic       ext_reset_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  output logic            int_n_out,
  // Address configuration
  input  wire logic       addr_sel_in,
  input  wire logic [6:0] addr_cfg_in,
  // Core events and requests
  input  wire logic       touch_detect_in,
  input  wire logic       data_ready_in,
  input  wire logic       monitor_req_in,
  input  wire logic       sleep_req_in,
  input  wire logic       wdog_kick_in,
  // Core access to the byte store
  input  wire logic       core_wr_en_in,
  input  wire logic [3:0] core_addr_in,
  input  wire logic [7:0] core_wdata_in,
  output logic      [7:0] core_rdata_out,
  // Status
  output logic      [1:0] mode_out,
  output logic            frame_tick_out,
  output logic            wdog_reset_out
);
  if (WDOG_CYC_P < 2 || WDOG_CYC_P > 16777215 || INIT_CYC_P < 1 || INIT_CYC_P > 16777215) begin : g_bad_cnt
    $error("touch_host_port counts out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] scl_s_r, sda_s_r, ext_s_r;
  logic       scl_f_r, sda_f_r, ext_f_r, scl_q_r, sda_q_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      ext_s_r <= 3'h0;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      ext_f_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      ext_s_r <= {ext_s_r[1:0], ext_reset_n_in};
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
      if (ext_s_r[1] == ext_s_r[2]) ext_f_r <= ext_s_r[2];
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
    end
  end

  // ----------------------------------------------------------------
  // Reset sources and mode
  // ----------------------------------------------------------------
  logic          wdog_fire_r;
  tp_pkg::mode_e mode_r, mode_nxt;
  logic [7:0]    act_fps_r, mon_fps_r;
  logic          host_wr;
  logic [3:0]    ptr_r, ptr_nxt;
  logic [7:0]    shift_r, shift_nxt;

  wire core_rst  = rst_in | ~ext_f_r | wdog_fire_r;
  wire port_open = (mode_r == tp_pkg::MODE_ACTIVE);
  wire in_sleep  = (mode_r == tp_pkg::MODE_SLEEP);
  wire mode_wr   = host_wr && ptr_r == tp_pkg::MODE_ADDR && shift_r[1:0] != 2'b11;

  always_comb begin
    mode_nxt = mode_r;
    if (core_rst) begin
      mode_nxt = tp_pkg::MODE_ACTIVE;
    end else if (in_sleep) begin
      mode_nxt = tp_pkg::MODE_SLEEP;
    end else if (sleep_req_in) begin
      mode_nxt = tp_pkg::MODE_SLEEP;
    end else if (mode_r == tp_pkg::MODE_MONITOR && touch_detect_in) begin
      mode_nxt = tp_pkg::MODE_ACTIVE;
    end else if (mode_wr) begin
      mode_nxt = tp_pkg::mode_e'(shift_r[1:0]);
    end else if (monitor_req_in && port_open) begin
      mode_nxt = tp_pkg::MODE_MONITOR;
    end
  end

  always_ff @(posedge clk_in) begin
    mode_r <= mode_nxt;
    if (core_rst) begin
      act_fps_r <= tp_pkg::DEF_ACT_FPS;
      mon_fps_r <= tp_pkg::DEF_MON_FPS;
    end else if (host_wr && ptr_r == tp_pkg::ACT_FPS_ADDR) begin
      act_fps_r <= shift_r;
    end else if (host_wr && ptr_r == tp_pkg::MON_FPS_ADDR) begin
      mon_fps_r <= shift_r;
    end
  end

  // ----------------------------------------------------------------
  // Frame rate: phase accumulator gives an exact long-term rate
  // ----------------------------------------------------------------
  logic [23:0] acc_r;
  wire  [7:0]  fps_sel  = (mode_r == tp_pkg::MODE_MONITOR) ? mon_fps_r : act_fps_r;
  wire  [24:0] acc_sum  = {1'b0, acc_r} + {17'h0, fps_sel};
  wire         acc_wrap = acc_sum >= {1'b0, tp_pkg::ACC_WRAP};
  wire  [24:0] acc_left = acc_sum - {1'b0, tp_pkg::ACC_WRAP};

  always_ff @(posedge clk_in) begin
    if (core_rst || in_sleep) begin
      acc_r          <= 24'h000000;
      frame_tick_out <= 1'b0;
    end else begin
      acc_r          <= acc_wrap ? acc_left[23:0] : acc_sum[23:0];
      frame_tick_out <= acc_wrap;
    end
  end

  // ----------------------------------------------------------------
  // I2C target
  // ----------------------------------------------------------------
  tp_pkg::i2c_st_e state_r, state_nxt;
  logic [3:0]      cnt_r, cnt_nxt;
  logic            ptr_set_r, ptr_set_nxt, drive_r, drive_nxt, rw_r, rw_nxt;
  logic [7:0]      mem_rdata;

  wire       scl_rise   = scl_f_r & ~scl_q_r;
  wire       scl_fall   = ~scl_f_r & scl_q_r;
  wire       start_det  = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
  wire       stop_det   = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;
  wire [6:0] dev_addr   = addr_sel_in ? addr_cfg_in : tp_pkg::DEF_DEV_ADDR;
  wire       addr_match = shift_r[7:1] == dev_addr;
  wire       byte_end   = scl_fall && cnt_r == tp_pkg::BYTE_BITS;
  wire       rd_claim   = port_open && state_r == tp_pkg::ST_ADDR && byte_end && addr_match && shift_r[0];
  wire [7:0] rd_byte    = (ptr_r == tp_pkg::MODE_ADDR)    ? {6'h00, mode_r} :
                          (ptr_r == tp_pkg::ACT_FPS_ADDR) ? act_fps_r :
                          (ptr_r == tp_pkg::MON_FPS_ADDR) ? mon_fps_r : mem_rdata;
  wire       load_rd    = scl_fall && ((state_r == tp_pkg::ST_ADDR_ACK && rw_r) || state_r == tp_pkg::ST_RD_ACK);
  assign host_wr = port_open && state_r == tp_pkg::ST_WR_DATA && byte_end && ptr_set_r;

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    shift_nxt   = shift_r;
    ptr_nxt     = ptr_r;
    ptr_set_nxt = ptr_set_r;
    drive_nxt   = drive_r;
    rw_nxt      = rw_r;
    if (!port_open) begin
      state_nxt = tp_pkg::ST_IDLE;
      drive_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = tp_pkg::ST_ADDR;
      cnt_nxt   = 4'h0;
      drive_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = tp_pkg::ST_IDLE;
      drive_nxt = 1'b0;
    end else if (load_rd) begin
      state_nxt = tp_pkg::ST_RD_DATA;
      shift_nxt = rd_byte;
      drive_nxt = ~rd_byte[7];
      cnt_nxt   = 4'h1;
      ptr_nxt   = ptr_r + 4'h1;
    end else begin
      unique case (state_r)
        tp_pkg::ST_IDLE: begin
        end
        tp_pkg::ST_ADDR, tp_pkg::ST_WR_DATA: begin
          if (scl_rise && cnt_r != tp_pkg::BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_f_r};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (byte_end) begin
            cnt_nxt = 4'h0;
            if (state_r == tp_pkg::ST_WR_DATA) begin
              state_nxt   = tp_pkg::ST_WR_ACK;
              drive_nxt   = 1'b1;
              ptr_set_nxt = 1'b1;
              ptr_nxt     = ptr_set_r ? ptr_r + 4'h1 : shift_r[3:0];
            end else if (addr_match) begin
              state_nxt = tp_pkg::ST_ADDR_ACK;
              drive_nxt = 1'b1;
              rw_nxt    = shift_r[0];
            end else begin
              state_nxt = tp_pkg::ST_IDLE;
            end
          end
        end
        tp_pkg::ST_ADDR_ACK, tp_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            state_nxt   = tp_pkg::ST_WR_DATA;
            drive_nxt   = 1'b0;
            ptr_set_nxt = (state_r == tp_pkg::ST_WR_ACK);
          end
        end
        tp_pkg::ST_RD_DATA: begin
          if (byte_end) begin
            state_nxt = tp_pkg::ST_RD_ACK;
            drive_nxt = 1'b0;
          end else if (scl_fall) begin
            shift_nxt = {shift_r[6:0], 1'b0};
            drive_nxt = ~shift_r[6];
            cnt_nxt   = cnt_r + 4'h1;
          end
        end
        tp_pkg::ST_RD_ACK: begin
          if (scl_rise && sda_f_r) begin
            state_nxt = tp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_nxt = tp_pkg::ST_IDLE;
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      state_r   <= tp_pkg::ST_IDLE;
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= 4'h0;
      ptr_set_r <= 1'b0;
      drive_r   <= 1'b0;
      rw_r      <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      shift_r   <= shift_nxt;
      ptr_r     <= ptr_nxt;
      ptr_set_r <= ptr_set_nxt;
      drive_r   <= drive_nxt;
      rw_r      <= rw_nxt;
    end
  end

  // Open drain: only ever pull data low; no clock output exists at all
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~(drive_r & port_open);

  tp_mem #(
    .AW (tp_pkg::MEM_AW),
    .DW (tp_pkg::MEM_DW)
  ) u_mem (
    .clk_in      (clk_in),
    .rst_in      (core_rst),
    .a_wr_en_in  (host_wr),
    .a_addr_in   (ptr_r),
    .a_wdata_in  (shift_r),
    .a_rdata_out (mem_rdata),
    .b_wr_en_in  (core_wr_en_in & ~in_sleep),
    .b_addr_in   (core_addr_in),
    .b_wdata_in  (core_wdata_in),
    .b_rdata_out (core_rdata_out)
  );

  // ----------------------------------------------------------------
  // Interrupt, init delay, watchdog
  // ----------------------------------------------------------------
  logic [23:0] init_cnt_r, wdog_cnt_r;
  logic        init_done_r, int_n_r;
  wire         int_set = data_ready_in & init_done_r & ~in_sleep;

  always_ff @(posedge clk_in) begin
    if (core_rst) begin
      init_cnt_r  <= 24'(INIT_CYC_P);
      init_done_r <= 1'b0;
      int_n_r     <= 1'b1;
      wdog_cnt_r  <= 24'(WDOG_CYC_P);
    end else begin
      if (!init_done_r) init_cnt_r <= init_cnt_r - 24'h000001;
      if (init_cnt_r == 24'h000001) init_done_r <= 1'b1;
      // A new report in the same cycle as the host claim keeps the line low
      if (int_set) int_n_r <= 1'b0;
      else if (rd_claim) int_n_r <= 1'b1;
      if (wdog_kick_in) wdog_cnt_r <= 24'(WDOG_CYC_P);
      else if (!in_sleep && wdog_cnt_r != 24'h000000) wdog_cnt_r <= wdog_cnt_r - 24'h000001;
    end
  end

  // The watchdog pulse resets everything but the pin synchronisers and then clears itself
  always_ff @(posedge clk_in) begin
    if (rst_in || !ext_f_r) wdog_fire_r <= 1'b0;
    else wdog_fire_r <= !wdog_fire_r && !wdog_kick_in && !in_sleep && wdog_cnt_r == 24'h000001;
  end

  assign int_n_out      = int_n_r;
  assign mode_out       = mode_r;
  assign wdog_reset_out = wdog_fire_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_pin_low;
    !ext_reset_n_in [*5];
  endsequence
  sequence s_addr_acked;
    state_r == tp_pkg::ST_ADDR ##1 state_r == tp_pkg::ST_ADDR_ACK;
  endsequence

  property p_reset_active;
    core_rst |=> mode_r == tp_pkg::MODE_ACTIVE && state_r == tp_pkg::ST_IDLE;
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("not Active after reset");
  property p_pin_reset;
    s_pin_low |-> ##[0:4] core_rst;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");
  property p_monitor_wake;
    mode_r == tp_pkg::MODE_MONITOR && touch_detect_in && !sleep_req_in && !core_rst
      |=> mode_r == tp_pkg::MODE_ACTIVE;
  endproperty
  a_monitor_wake: assert property (p_monitor_wake) else $error("touch did not wake");
  property p_port_closed;
    mode_r != tp_pkg::MODE_ACTIVE |-> sda_oe_n_out && !rd_claim && !host_wr;
  endproperty
  a_port_closed: assert property (p_port_closed) else $error("port active outside Active");
  property p_sleep_hold;
    in_sleep && !core_rst |=> in_sleep && !frame_tick_out;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left Sleep without reset");
  property p_int_set;
    int_set && !core_rst |=> !int_n_out;
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt not raised");
  property p_int_init;
    !init_done_r |-> int_n_out;
  endproperty
  a_int_init: assert property (p_int_init) else $error("interrupt before init");
  property p_addr_ack;
    s_addr_acked |-> shift_r[7:1] == (addr_sel_in ? addr_cfg_in : tp_pkg::DEF_DEV_ADDR) && !sda_oe_n_out;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("ack for wrong address");
  property p_start;
    port_open && start_det && !core_rst |=> state_r == tp_pkg::ST_ADDR && cnt_r == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    port_open && stop_det && !start_det && !core_rst |=> state_r == tp_pkg::ST_IDLE && sda_oe_n_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_drive_states;
    !sda_oe_n_out |-> state_r inside {tp_pkg::ST_ADDR_ACK, tp_pkg::ST_WR_ACK, tp_pkg::ST_RD_DATA};
  endproperty
  a_drive_states: assert property (p_drive_states) else $error("data driven out of turn");
  property p_wdog;
    wdog_cnt_r == 24'h000001 && !wdog_kick_in && !in_sleep && !core_rst |=> wdog_reset_out ##1 mode_r == tp_pkg::MODE_ACTIVE;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not fire");
  property p_rate_write;
    host_wr && ptr_r == tp_pkg::ACT_FPS_ADDR && !core_rst |=> act_fps_r == $past(shift_r);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate write lost");
  property p_frame_tick;
    frame_tick_out |=> !frame_tick_out [*8];
  endproperty
  a_frame_tick: assert property (p_frame_tick) else $error("frame ticks too close");
endmodule
`default_nettype wire

// file: verification/i2c_host_model.sv
// Host-side I2C controller model that drives the target's bus pins
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // Bus pins, open drain with pull-ups
  input  wire logic sda_line_in,
  output logic      scl_out,
  output logic      sda_drv_out
);
  // ----------
  // Bus idles released; the clock stands still between frames
  // ----------
  initial begin
    scl_out     = 1'b1;
    sda_drv_out = 1'b1;
  end

  // 800 ns per bit; extra low time at byte edges lets the target's filtered pins settle
  // Low time of 500 ns: the target moves its data about 5 clocks after the pin falls,
  // so a shorter low phase would have it change SDA while SCL is already high
  task automatic bit_io(input logic b, input int pre, output logic got);
    #(pre);
    sda_drv_out = b;
    #400;
    scl_out = 1'b1;
    #300;
    got = sda_line_in;
    scl_out = 1'b0;
    #100;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], (i == 7) ? 400 : 0, q[i]);
    end
    bit_io(ack, 400, ack_seen);
  endtask

  // Works from idle and as a repeated start
  task automatic start_cond();
    #400;
    sda_drv_out = 1'b1;
    #300;
    scl_out = 1'b1;
    #400;
    sda_drv_out = 1'b0;
    #400;
    scl_out = 1'b0;
    #100;
  endtask

  task automatic stop_cond();
    #400;
    sda_drv_out = 1'b0;
    #300;
    scl_out = 1'b1;
    #400;
    sda_drv_out = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the touch controller host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    check_count++; \
    if ((gt) !== (ex)) begin \
      num_errors++; \
      $display("BAD %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module tb_top;
  // ----------
  // Signals and instances
  // ----------
  localparam int WDOG_P = 50;
  localparam int INIT_P = 20;
  logic       clk_in          = 1'b0;
  logic       rst_in          = 1'b1;
  logic       ext_reset_n_in  = 1'b1;
  logic       addr_sel_in     = 1'b0;
  logic [6:0] addr_cfg_in     = 7'h00;
  logic       touch_detect_in = 1'b0;
  logic       data_ready_in   = 1'b0;
  logic       monitor_req_in  = 1'b0;
  logic       sleep_req_in    = 1'b0;
  logic       wdog_kick_in    = 1'b0;
  logic       core_wr_en_in   = 1'b0;
  logic [3:0] core_addr_in    = 4'h0;
  logic [7:0] core_wdata_in   = 8'h00;
  logic       kick_en         = 1'b1;
  logic       scl_in, sda_drv, sda_out, sda_oe_n_out, int_n_out, frame_tick_out, wdog_reset_out;
  logic [7:0] core_rdata_out;
  logic [1:0] mode_out;
  logic [7:0] mdl_mem [16];
  wire        sda_in          = sda_drv & (sda_oe_n_out | sda_out);
  int         num_errors      = 0;
  int         check_count     = 0;

  always #50 clk_in = ~clk_in;
  // Random kicks keep the shortened watchdog fed; fifty misses in a row are negligible
  always @(posedge clk_in) wdog_kick_in <= #1 kick_en && ($urandom_range(0, 1) == 1);

  touch_host_port #(.WDOG_CYC_P(WDOG_P), .INIT_CYC_P(INIT_P)) i_dut (
    .clk_in, .rst_in, .ext_reset_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out, .int_n_out,
    .addr_sel_in, .addr_cfg_in, .touch_detect_in, .data_ready_in, .monitor_req_in, .sleep_req_in,
    .wdog_kick_in, .core_wr_en_in, .core_addr_in, .core_wdata_in, .core_rdata_out, .mode_out,
    .frame_tick_out, .wdog_reset_out
  );
  i2c_host_model i_host (.sda_line_in(sda_in), .scl_out(scl_in), .sda_drv_out(sda_drv));

  // ----------
  // Tasks
  // ----------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic mdl_reset();
    foreach (mdl_mem[i]) mdl_mem[i] = 8'h00;
    mdl_mem[1] = 8'h64;
    mdl_mem[2] = 8'h19;
  endtask

  task automatic addr_phase(input logic [6:0] a, input logic rd, input logic exp_ack);
    logic [7:0] q;
    logic       ak;
    i_host.start_cond();
    i_host.byte_io({a, rd}, 1'b1, q, ak);
    `CHK("address ack", exp_ack, ~ak)
  endtask

  task automatic host_write(input logic [3:0] ptr, input logic [7:0] dq[$]);
    logic [7:0] q;
    logic       ak;
    addr_phase(7'h70, 1'b0, 1'b1);
    i_host.byte_io({4'h0, ptr}, 1'b1, q, ak);
    `CHK("pointer ack", 1'b0, ak)
    foreach (dq[i]) begin
      i_host.byte_io(dq[i], 1'b1, q, ak);
      `CHK("data ack", 1'b0, ak)
      mdl_mem[(ptr + i) % 16] = dq[i];
    end
    i_host.stop_cond();
  endtask

  task automatic host_read(input logic [3:0] ptr, input int n);
    logic [7:0] q;
    logic       ak;
    addr_phase(7'h70, 1'b0, 1'b1);
    i_host.byte_io({4'h0, ptr}, 1'b1, q, ak);
    addr_phase(7'h70, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_host.byte_io(8'hFF, (i == n - 1), q, ak);
      `CHK("read byte", mdl_mem[(ptr + i) % 16], q)
    end
    i_host.stop_cond();
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #11_000_000;
    num_errors++;
    $display("BAD run_time expected finish seen timeout");
    stop_test();
  end

  initial begin
    logic [7:0] dq[$];
    logic [6:0] cfg;
    int         n;
    logic       seen;
    logic [7:0] q;
    logic       ak;
    void'($urandom(32'hCBC8));
    mdl_reset();
    tick(10);
    `CHK("reset mode", tp_pkg::MODE_ACTIVE, mode_out)
    rst_in = 1'b0;
    tick(6);
    pulse(data_ready_in);
    tick(2);
    `CHK("int during init", 1'b1, int_n_out)
    tick(INIT_P + 10);
    pulse(data_ready_in);
    tick(1);
    `CHK("int raised", 1'b0, int_n_out)
    host_read(4'h0, 3);
    `CHK("int cleared", 1'b1, int_n_out)
    `CHK("open drain level", 1'b0, sda_out)
    repeat (5) dq.push_back(8'($urandom));
    host_write(4'h3, dq);
    core_wr_en_in = 1'b1;
    core_addr_in  = 4'h9;
    core_wdata_in = 8'($urandom);
    tick(1);
    core_wr_en_in = 1'b0;
    mdl_mem[9]    = core_wdata_in;
    tick(1);
    `CHK("core read", mdl_mem[9], core_rdata_out)
    host_read(4'h3, 7);
    addr_phase(7'h71, 1'b0, 1'b0);
    i_host.stop_cond();
    cfg         = {3'b001, 4'($urandom)};
    addr_sel_in = 1'b1;
    addr_cfg_in = cfg;
    tick(2);
    addr_phase(cfg, 1'b0, 1'b1);
    i_host.stop_cond();
    addr_phase(7'h70, 1'b0, 1'b0);
    i_host.stop_cond();
    addr_sel_in = 1'b0;
    tick(2);
    dq = {8'hFA, 8'($urandom_range(1, 255))};
    host_write(4'h1, dq);
    host_read(4'h1, 2);
    n = 0;
    while (frame_tick_out !== 1'b1 && n < 45000) begin
      tick(1);
      n++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while (frame_tick_out !== 1'b1 && n < 45000);
    `CHK("active frame period", 10_000_000 / 250, n)
    pulse(monitor_req_in);
    tick(1);
    `CHK("monitor mode", tp_pkg::MODE_MONITOR, mode_out)
    addr_phase(7'h70, 1'b0, 1'b0);
    i_host.stop_cond();
    pulse(touch_detect_in);
    tick(1);
    `CHK("touch wake", tp_pkg::MODE_ACTIVE, mode_out)
    // Host writes Monitor into the mode byte: the port shuts before its own ACK
    addr_phase(7'h70, 1'b0, 1'b1);
    i_host.byte_io(8'h00, 1'b1, q, ak);
    `CHK("mode pointer ack", 1'b0, ak)
    i_host.byte_io({6'h00, tp_pkg::MODE_MONITOR}, 1'b1, q, ak);
    `CHK("mode write nack", 1'b1, ak)
    i_host.stop_cond();
    `CHK("mode write", tp_pkg::MODE_MONITOR, mode_out)
    pulse(touch_detect_in);
    tick(1);
    `CHK("touch wake again", tp_pkg::MODE_ACTIVE, mode_out)
    pulse(sleep_req_in);
    tick(1);
    `CHK("sleep mode", tp_pkg::MODE_SLEEP, mode_out)
    pulse(touch_detect_in);
    pulse(data_ready_in);
    tick(2);
    `CHK("sleep holds", tp_pkg::MODE_SLEEP, mode_out)
    `CHK("sleep int", 1'b1, int_n_out)
    addr_phase(7'h70, 1'b1, 1'b0);
    i_host.stop_cond();
    ext_reset_n_in = 1'b0;
    tick(6);
    ext_reset_n_in = 1'b1;
    tick(10);
    `CHK("pin wake", tp_pkg::MODE_ACTIVE, mode_out)
    mdl_reset();
    tick(INIT_P);
    host_read(4'h1, 2);
    pulse(monitor_req_in);
    kick_en = 1'b0;
    seen    = 1'b0;
    for (int i = 0; i < WDOG_P + 10 && !seen; i++) begin
      tick(1);
      seen = (wdog_reset_out === 1'b1);
    end
    `CHK("watchdog fired", 1'b1, seen)
    kick_en = 1'b1;
    tick(10);
    `CHK("watchdog restart", tp_pkg::MODE_ACTIVE, mode_out)
    stop_test();
  end
endmodule
`default_nettype wire
